// >>> inc/sdram_init_pkg.sv
// Purpose: Shared constants for the memory-side init and mode load block
// Assumes: Clock runs at 10 MHz
// Notes: Command codes are the usual chip-select, row, column and write-enable patterns
package sdram_init_pkg;
  localparam int CLK_MHZ = 10;
  localparam int CLK_PERIOD_NS = 100;
  localparam int DLL_LOCK_CYCLES = 512;
  localparam int CKE_MIN_CLOCKS = 5;
  // Command encoding {csN, rasN, casN, weN}
  localparam logic [3:0] CMD_MODE_LOAD = 4'h0;
  localparam logic [3:0] CMD_CALIB = 4'h6;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam int MODE_WIDTH = 17;
  localparam logic [2:0] BANK_MODE_ZERO = 3'h0;
  localparam logic [2:0] BANK_MODE_ONE = 3'h1;
  localparam logic [2:0] BANK_MODE_TWO = 3'h2;
  localparam logic [2:0] BANK_MODE_THREE = 3'h3;
  // Mode zero field positions
  localparam int BL_LSB = 0;
  localparam int BTYPE_BIT = 3;
  localparam int DLL_RST_BIT = 8;
  localparam int BSEL_BIT = 12;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_CHOP4 = 2'h2;
  localparam logic [16:0] MODE_RESET = 17'h0_0000;
endpackage : sdram_init_pkg

// >>> rtl/burst_column_gen.sv
// Purpose: Column sequence for one burst, wrapping inside its block
// Assumes: Start column and lengths are held stable while a burst runs
// Notes: Beat index counts 0..7
`timescale 1ns/1ps
module burst_column_gen
  import sdram_init_pkg::*;
#(
  parameter int COL_W = 10
)(
  input wire logic [COL_W-1:0] startCol,
  input wire logic [2:0] beat,
  input wire logic chop,
  input wire logic interleave,
  output logic [COL_W-1:0] col
);
  logic [2:0] low;
  // Block select stays fixed; only low bits move, so the burst wraps
  always_comb
  begin
    if (interleave)
      low = startCol[2:0] ^ beat;
    else if (chop)
      low = {startCol[2], startCol[1:0] + beat[1:0]};
    else
      low = startCol[2:0] + beat;
    if (chop)
      col = {startCol[COL_W-1:3], startCol[2], low[1:0]};
    else
      col = {startCol[COL_W-1:3], low};
  end
endmodule : burst_column_gen

// >>> rtl/sdram_init_mode.sv
// Purpose: Device-side init tracking, mode storage and burst control
// Assumes: Controller keeps its own timing; pins are synchronised here
// Notes: Termination output enable is low until clock gate is seen high
`timescale 1ns/1ps
// What this block does
// - Termination stays high impedance under reset until clock gate seen high.
// - DLL needs 512 cycles to lock after DLL reset.
// - Mode registers hold until rewritten or reset; DLL reset bit self-clears.
// - Only idle commands until mode-to-other gap; features unavailable meanwhile. Here only modeReady drops; commands are still taken.
// - Burst length field picks chop four, eight, or per-command select bit.
// - Burst stays in its column block, wrapping; low bits give start.
// - Programmed burst length applies to reads and writes alike.
// - Writing DLL reset bit starts DLL reset, then bit clears itself.
// - Mode zero bit 3 selects sequential or interleaved order.
module sdram_init_mode
  import sdram_init_pkg::*;
#(
  parameter int COL_W = 10,
  parameter int MOD_GAP = 12
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic resetPinN,
  input wire logic clockGate,
  input wire logic terminationControl,
  input wire logic [3:0] cmd,
  input wire logic [2:0] bankSel,
  input wire logic [16:0] addr,
  output logic terminationOe,
  output logic terminationOn,
  output logic dllLocked,
  output logic modeReady,
  output logic burstActive,
  output logic burstWrite,
  output logic [COL_W-1:0] burstCol,
  output logic [16:0] modeZero,
  output logic [16:0] modeOne,
  output logic [16:0] modeTwo,
  output logic [16:0] modeThree,
  output logic initDone
);
  typedef enum logic [2:0] {S_RESET, S_WAIT_GATE, S_LOAD2, S_LOAD3, S_LOAD1, S_LOAD0,
    S_CALIB, S_DONE} init_t;
  // Two-flop synchronisers on every pin input
  logic [1:0] rstSync_ff, gateSync_ff, termSync_ff;
  logic [3:0] cmdA_ff, cmdB_ff;
  logic [2:0] bankA_ff, bankB_ff;
  logic [16:0] addrA_ff, addrB_ff;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rstSync_ff <= 2'h0;
      gateSync_ff <= 2'h0;
      termSync_ff <= 2'h0;
      cmdA_ff <= CMD_NOP;
      cmdB_ff <= CMD_NOP;
      bankA_ff <= 3'h0;
      bankB_ff <= 3'h0;
      addrA_ff <= 17'h0_0000;
      addrB_ff <= 17'h0_0000;
    end
    else
    begin
      rstSync_ff <= {rstSync_ff[0], resetPinN};
      gateSync_ff <= {gateSync_ff[0], clockGate};
      termSync_ff <= {termSync_ff[0], terminationControl};
      cmdA_ff <= cmd;
      cmdB_ff <= cmdA_ff;
      bankA_ff <= bankSel;
      bankB_ff <= bankA_ff;
      addrA_ff <= addr;
      addrB_ff <= addrA_ff;
    end
  end
  logic pinRstN, gateHigh, modeLoad, anyCmd;
  assign pinRstN = rstSync_ff[1];
  assign gateHigh = gateSync_ff[1];
  assign modeLoad = gateHigh && (cmdB_ff == CMD_MODE_LOAD);
  assign anyCmd = gateHigh && (cmdB_ff != CMD_NOP) && !cmdB_ff[3];

  init_t state_ff;
  // Sequence tracker: follows expected load order two, three, one, zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_ff <= S_RESET;
    else if (!pinRstN)
      state_ff <= S_RESET;
    else
      unique case (state_ff)
        S_RESET: state_ff <= S_WAIT_GATE;
        S_WAIT_GATE: if (gateHigh) state_ff <= S_LOAD2;
        S_LOAD2: if (modeLoad && bankB_ff == BANK_MODE_TWO) state_ff <= S_LOAD3;
        S_LOAD3: if (modeLoad && bankB_ff == BANK_MODE_THREE) state_ff <= S_LOAD1;
        S_LOAD1: if (modeLoad && bankB_ff == BANK_MODE_ONE) state_ff <= S_LOAD0;
        S_LOAD0: if (modeLoad && bankB_ff == BANK_MODE_ZERO) state_ff <= S_CALIB;
        S_CALIB: if (anyCmd && cmdB_ff == CMD_CALIB) state_ff <= S_DONE;
        S_DONE: state_ff <= S_DONE;
      endcase
  end

  // Mode storage; cleared by reset pin, held otherwise; DLL bit never stored
  logic [16:0] mode0_ff, mode1_ff, mode2_ff, mode3_ff;
  logic dllReset;
  assign dllReset = modeLoad && bankB_ff == BANK_MODE_ZERO && addrB_ff[DLL_RST_BIT];
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode0_ff <= MODE_RESET;
      mode1_ff <= MODE_RESET;
      mode2_ff <= MODE_RESET;
      mode3_ff <= MODE_RESET;
    end
    else if (!pinRstN)
    begin
      mode0_ff <= MODE_RESET;
      mode1_ff <= MODE_RESET;
      mode2_ff <= MODE_RESET;
      mode3_ff <= MODE_RESET;
    end
    else if (modeLoad)
    begin
      unique case (bankB_ff)
        BANK_MODE_ZERO: mode0_ff <= addrB_ff & ~(17'h0_0001 << DLL_RST_BIT);
        BANK_MODE_ONE: mode1_ff <= addrB_ff;
        BANK_MODE_TWO: mode2_ff <= addrB_ff;
        BANK_MODE_THREE: mode3_ff <= addrB_ff;
        default: ;
      endcase
    end
  end

  // DLL lock counter restarts on each DLL reset
  logic [9:0] lockCnt_ff;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      lockCnt_ff <= 10'h000;
    else if (!pinRstN || dllReset)
      lockCnt_ff <= 10'h000;
    else if (gateHigh && lockCnt_ff < 10'(DLL_LOCK_CYCLES))
      lockCnt_ff <= lockCnt_ff + 10'h001;
  end

  // Mode-to-other gap: modeReady held low until it runs out; commands still accepted
  logic [7:0] modGap_ff;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      modGap_ff <= 8'h00;
    else if (modeLoad)
      modGap_ff <= 8'(MOD_GAP);
    else if (modGap_ff != 8'h00)
      modGap_ff <= modGap_ff - 8'h01;
  end

  // Termination: high impedance until gate seen high since reset
  logic gateSeen_ff;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      gateSeen_ff <= 1'b0;
    else if (!pinRstN)
      gateSeen_ff <= 1'b0;
    else if (gateHigh)
      gateSeen_ff <= 1'b1;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      terminationOe <= 1'b0;
      terminationOn <= 1'b0;
    end
    else
    begin
      terminationOe <= pinRstN && gateSeen_ff;
      terminationOn <= pinRstN && gateSeen_ff && termSync_ff[1];
    end
  end

  // Burst engine: length from mode zero, select bit in on-the-fly mode
  logic [2:0] beat_ff;
  logic chop_ff, inter_ff;
  logic [COL_W-1:0] startCol_ff, colNext;
  logic isRw, cmdChop;
  assign isRw = gateHigh && (cmdB_ff == CMD_READ || cmdB_ff == CMD_WRITE);
  always_comb
  begin
    unique case (mode0_ff[BL_LSB+1:BL_LSB])
      BL_OTF: cmdChop = !addrB_ff[BSEL_BIT];
      BL_CHOP4: cmdChop = 1'b1;
      default: cmdChop = 1'b0;
    endcase
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      burstActive <= 1'b0;
      burstWrite <= 1'b0;
      beat_ff <= 3'h0;
      chop_ff <= 1'b0;
      inter_ff <= 1'b0;
      startCol_ff <= '0;
    end
    else if (isRw && !burstActive)
    begin
      burstActive <= 1'b1;
      burstWrite <= (cmdB_ff == CMD_WRITE);
      beat_ff <= 3'h0;
      chop_ff <= cmdChop;
      inter_ff <= mode0_ff[BTYPE_BIT];
      startCol_ff <= addrB_ff[COL_W-1:0];
    end
    else if (burstActive)
    begin
      beat_ff <= beat_ff + 3'h1;
      if (beat_ff == (chop_ff ? 3'h3 : 3'h7))
        burstActive <= 1'b0;
    end
  end
  burst_column_gen #(.COL_W(COL_W)) u_col (
    .startCol(startCol_ff),
    .beat(beat_ff),
    .chop(chop_ff),
    .interleave(inter_ff),
    .col(colNext)
  );
  // Registered outputs
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      burstCol <= '0;
      dllLocked <= 1'b0;
      modeReady <= 1'b0;
      initDone <= 1'b0;
      modeZero <= MODE_RESET;
      modeOne <= MODE_RESET;
      modeTwo <= MODE_RESET;
      modeThree <= MODE_RESET;
    end
    else
    begin
      burstCol <= colNext;
      dllLocked <= !dllReset && lockCnt_ff >= 10'(DLL_LOCK_CYCLES);
      modeReady <= (modGap_ff == 8'h00) && !modeLoad;
      initDone <= (state_ff == S_DONE) && lockCnt_ff >= 10'(DLL_LOCK_CYCLES);
      modeZero <= mode0_ff;
      modeOne <= mode1_ff;
      modeTwo <= mode2_ff;
      modeThree <= mode3_ff;
    end
  end

  a_term_hiz_reset: assert property (@(posedge clk) disable iff (rst)
    !gateSeen_ff |=> !terminationOe) else $error("termination driven early");
  a_dll_bit_clear: assert property (@(posedge clk) disable iff (rst)
    !mode0_ff[DLL_RST_BIT]) else $error("dll reset bit stuck");
  a_lock_time: assert property (@(posedge clk) disable iff (rst)
    dllReset |=> !dllLocked [*8]) else $error("dll locked too soon");
  a_mode_gap: assert property (@(posedge clk) disable iff (rst)
    modeLoad |=> !modeReady [*8]) else $error("mode gap short");
  a_chop_len: assert property (@(posedge clk) disable iff (rst)
    (burstActive && chop_ff && beat_ff == 3'h3) |=> !burstActive)
    else $error("chop burst length wrong");
  a_block_fix: assert property (@(posedge clk) disable iff (rst)
    burstActive |=> burstCol[COL_W-1:3] == startCol_ff[COL_W-1:3])
    else $error("burst left block");
  a_reset_clear: assert property (@(posedge clk) disable iff (rst)
    !pinRstN |=> mode1_ff == MODE_RESET) else $error("mode not cleared");
  a_burst_type: assert property (@(posedge clk) disable iff (rst)
    (isRw && !burstActive) |=> inter_ff == $past(mode0_ff[BTYPE_BIT]))
    else $error("burst type not taken");
  c_init_done: cover property (@(posedge clk) initDone);
  c_otf_chop: cover property (@(posedge clk) isRw && mode0_ff[1:0] == BL_OTF);
  c_dll_reset: cover property (@(posedge clk) dllReset);
endmodule : sdram_init_mode

// >>> bench/ctrl_model.sv
// Purpose: Controller-side model driving the init pins and commands
// Assumes: Hold and wait times are short cycle counts for simulation
// Notes: Idle address shows the inverse of the last one, never a stale copy
`timescale 1ns/1ps
module ctrl_model
  import sdram_init_pkg::*;
#(
  parameter int HOLD = 8,
  parameter int GATE_LOW = 6,
  parameter int XPR = 5,
  parameter int GAP = 16
)(
  input wire logic clk,
  output logic resetPinN,
  output logic clockGate,
  output logic terminationControl,
  output logic [3:0] cmd,
  output logic [2:0] bankSel,
  output logic [16:0] addr
);
  // Power-off levels; termination request starts low
  initial
  begin
    resetPinN = 1'b0;
    clockGate = 1'b0;
    terminationControl = 1'b0;
    cmd = CMD_NOP;
    bankSel = 3'h0;
    addr = 17'h0_0000;
  end
  // Reset hold, gate low time, then gate high until a pin reset drops it
  task power_up();
    repeat (HOLD) @(posedge clk);
    resetPinN <= 1'b1;
    repeat (GATE_LOW) @(posedge clk);
    clockGate <= 1'b1;
    repeat (XPR) @(posedge clk);
  endtask : power_up
  // Termination request level, changed just after an edge
  task set_term(input logic v);
    @(posedge clk);
    terminationControl <= v;
  endtask : set_term
  // Pin reset drops the gate as well, as at power-up
  task pin_reset();
    @(posedge clk);
    resetPinN <= 1'b0;
    clockGate <= 1'b0;
  endtask : pin_reset
  // One command cycle, then no-operation
  task issue(input logic [3:0] c, input logic [2:0] b, input logic [16:0] a);
    @(posedge clk);
    cmd <= c;
    bankSel <= b;
    addr <= a;
    @(posedge clk);
    cmd <= CMD_NOP;
    addr <= ~a;
  endtask : issue
  // Whole-field load, then the gap before anything else
  task mode_load(input logic [2:0] b, input logic [16:0] v);
    issue(CMD_MODE_LOAD, b, v);
    repeat (GAP) @(posedge clk);
  endtask : mode_load
endmodule : ctrl_model

// >>> bench/sdram_init_mode_tb.sv
// Purpose: Self-checking bench for init tracking, mode storage and bursts
// Assumes: Column address rides on addr[9:0]
// Notes: Column block is judged one cycle after each active beat
`timescale 1ns/1ps
module sdram_init_mode_tb;
  import sdram_init_pkg::*;
  logic clk, rst, resetPinN, clockGate, terminationControl;
  logic terminationOe, terminationOn, dllLocked, modeReady, burstActive, burstWrite, initDone;
  logic [3:0] cmd;
  logic [2:0] bankSel;
  logic [16:0] addr, modeZero, modeOne, modeTwo, modeThree;
  logic [9:0] burstCol;
  int n_errors, n_compared, cnt;

  sdram_init_mode #(.COL_W(10), .MOD_GAP(12)) u_sdram_init_mode (.clk(clk), .rst(rst),
    .resetPinN(resetPinN), .clockGate(clockGate), .terminationControl(terminationControl),
    .cmd(cmd), .bankSel(bankSel), .addr(addr), .terminationOe(terminationOe),
    .terminationOn(terminationOn), .dllLocked(dllLocked), .modeReady(modeReady),
    .burstActive(burstActive), .burstWrite(burstWrite), .burstCol(burstCol),
    .modeZero(modeZero), .modeOne(modeOne), .modeTwo(modeTwo), .modeThree(modeThree),
    .initDone(initDone));
  ctrl_model #(.GAP(16)) u_ctrl_model (.clk(clk), .resetPinN(resetPinN),
    .clockGate(clockGate), .terminationControl(terminationControl), .cmd(cmd),
    .bankSel(bankSel), .addr(addr));

  // Free-running 10 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Compare one value, count and report
  task check(input string name, input logic [16:0] seen, input logic [16:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Single closing point for normal end and timeouts
  task complete_run();
    $display("Compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  // One burst; beats counted, columns kept in their block
  task burst(input logic [3:0] c, input logic [16:0] a, input int len, input int lsb,
    input logic il);
    int n;
    logic [2:0] lo;
    logic [9:0] ec;
    int k;
    logic prev;
    n = 0;
    k = 0;
    prev = 1'b0;
    u_ctrl_model.issue(c, 3'h0, a);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      #1;
      if (prev)
      begin
        check("colBlock", 17'(burstCol >> lsb), 17'(a[9:0] >> lsb));
        if (k == 0)
          check("colStart", 17'(burstCol), 17'(a[9:0]));
        // Expected order: sequential adds, interleaved flips, both inside the block
        lo = il ? (a[2:0] ^ 3'(k)) : (a[2:0] + 3'(k));
        ec = (len == 4) ? {a[9:2], lo[1:0]} : {a[9:3], lo};
        check("colOrder", 17'(burstCol), 17'(ec));
        k++;
      end
      if (burstActive === 1'b1)
      begin
        n++;
        check("dir", 17'(burstWrite), 17'(c == CMD_WRITE));
      end
      prev = burstActive;
    end
    check("beats", 17'(n), 17'(len));
  endtask : burst

  // Main sequence: init, mode checks, bursts, pin reset
  initial
  begin
    n_errors = 0;
    n_compared = 0;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    u_ctrl_model.power_up();
    #1;
    check("oeAfterGate", 17'(terminationOe), 17'h0_0001);
    u_ctrl_model.mode_load(BANK_MODE_TWO, 17'h0_0018);
    u_ctrl_model.mode_load(BANK_MODE_THREE, 17'h0_0004);
    u_ctrl_model.mode_load(BANK_MODE_ONE, 17'h0_0044);
    u_ctrl_model.issue(CMD_MODE_LOAD, BANK_MODE_ZERO, 17'h0_0120);
    repeat (3) @(posedge clk);
    #1;
    check("readyLow", 17'(modeReady), 17'h0_0000);
    check("dllEarly", 17'(dllLocked), 17'h0_0000);
    // Lock wait bounded well past the lock count
    for (cnt = 3; cnt < 600 && dllLocked !== 1'b1; cnt++)
    begin
      @(posedge clk);
      #1;
    end
    if (cnt >= 600)
    begin
      n_errors++;
      complete_run();
    end
    check("lockTime", 17'(cnt >= DLL_LOCK_CYCLES && cnt <= DLL_LOCK_CYCLES + 6), 17'h1);
    check("readyBack", 17'(modeReady), 17'h0_0001);
    check("modeTwo", modeTwo, 17'h0_0018);
    check("modeThree", modeThree, 17'h0_0004);
    check("modeOne", modeOne, 17'h0_0044);
    check("modeZero", modeZero, 17'h0_0020);
    check("initEarly", 17'(initDone), 17'h0_0000);
    u_ctrl_model.issue(CMD_CALIB, 3'h0, 17'h0_0400);
    repeat (8) @(posedge clk);
    #1;
    check("initDone", 17'(initDone), 17'h0_0001);
    // Termination follows its request once enabled, then drops before the next loads
    u_ctrl_model.set_term(1'b1);
    repeat (4) @(posedge clk);
    #1;
    check("termOn", 17'(terminationOn), 17'h0_0001);
    u_ctrl_model.set_term(1'b0);
    // A second DLL reset must drop the lock at once
    u_ctrl_model.issue(CMD_MODE_LOAD, BANK_MODE_ZERO, 17'h0_0100);
    repeat (2) @(posedge clk);
    #1;
    check("relockLow", 17'(dllLocked), 17'h0_0000);
    repeat (16) @(posedge clk);
    // Every burst length code, both orders, reads and writes
    u_ctrl_model.mode_load(BANK_MODE_ZERO, 17'(BL_CHOP4));
    burst(CMD_READ, 17'h0_00D5, 4, 2, 1'b0);
    u_ctrl_model.mode_load(BANK_MODE_ZERO, 17'(BL_FIXED8) | 17'h0_0008);
    burst(CMD_WRITE, 17'h0_00D5, 8, 3, 1'b1);
    u_ctrl_model.mode_load(BANK_MODE_ZERO, 17'(BL_OTF));
    burst(CMD_READ, 17'h0_00D6, 4, 2, 1'b0);
    burst(CMD_WRITE, 17'h0_10D6, 8, 3, 1'b0);
    u_ctrl_model.mode_load(BANK_MODE_ZERO, 17'(BL_CHOP4) | 17'h0_0008);
    burst(CMD_READ, 17'h0_00D7, 4, 2, 1'b1);
    u_ctrl_model.pin_reset();
    repeat (6) @(posedge clk);
    #1;
    check("modeCleared", modeZero, 17'h0_0000);
    check("oeReset", 17'(terminationOe), 17'h0_0000);
    check("termReset", 17'(terminationOn), 17'h0_0000);
    complete_run();
  end
endmodule : sdram_init_mode_tb
